// File: verilog/ibc_bus_ctrl.sv
`timescale 1ns/10ps
`include "ibc_cfg.svh"
module ibc_bus_ctrl #(
    parameter int LOW_CYC = `IBC_LOW_CYC,
    parameter int HIGH_CYC = `IBC_HIGH_CYC
) (
    input wire logic pclk,                        // system clock, 20 MHz
    input wire logic presetn,                     // async reset, active low
    input wire logic psel,                        // apb select
    input wire logic penable,                     // apb access phase
    input wire logic pwrite,                      // apb direction
    input wire logic [11:0] paddr,                // apb byte address
    input wire logic [31:0] pwdata,               // apb write data
    output logic [31:0] prdata,                   // apb read data
    output logic pready,                          // apb ready
    output logic pslverr,                         // unmapped address
    input wire logic clock_line_pin_i,            // bus clock level
    input wire logic data_line_pin_i,             // bus data level
    output ibc_pkg::ibc_pad_t clock_line_pad,     // clock pad drive
    output ibc_pkg::ibc_pad_t data_line_pad,      // data pad drive
    output logic transfer_irq                     // one-cycle word-end pulse
);
    localparam logic [7:0] LOW_T = 8'(LOW_CYC);
    localparam logic [7:0] HIGH_T = 8'(HIGH_CYC);

    // timer is eight bits wide
    if (LOW_CYC < 1 || LOW_CYC > 255 || HIGH_CYC < 1 || HIGH_CYC > 255)
    begin : g_bad_timing
        $error("ibc_bus_ctrl: LOW_CYC and HIGH_CYC must lie in 1..255");
    end

    ibc_pkg::ibc_state_t q, d;
    logic acc, wr, dbr_acc, cr2_wr, start_req, stop_req;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic addr, match, data_done;
    logic [3:0] wbits, wlen;
    logic [3:0] bit_idx;

    // bus conditions seen through the synchronisers
    assign scl_rise = q.sy.scl_s & ~q.sy.scl_p;
    assign scl_fall = ~q.sy.scl_s & q.sy.scl_p;
    assign start_det = q.sy.scl_s & q.sy.scl_p & ~q.sy.sda_s & q.sy.sda_p;
    assign stop_det = q.sy.scl_s & q.sy.scl_p & q.sy.sda_s & ~q.sy.sda_p;

    // apb decode; the slave always answers without wait states
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign dbr_acc = acc & (paddr == `IBC_OFF_DBR);
    assign cr2_wr = wr & (paddr == `IBC_OFF_CR2);
    assign start_req = cr2_wr & (pwdata[7:4] == 4'hf);
    assign stop_req = cr2_wr & pwdata[`IBC_MST_BIT] & ~pwdata[`IBC_BB_BIT]
        & pwdata[`IBC_PIN_BIT] & q.master_select & (q.ph == ibc_pkg::ST_XFER);

    // word length: zero code means eight bits, plus the ack clock when ack mode is on
    assign wbits = (q.bc == 3'h0) ? 4'h8 : {1'b0, q.bc};
    assign wlen = wbits + {3'h0, q.ack_en};
    assign data_done = (q.bit_cnt == wbits);
    assign addr = q.first & ~q.free_format_select & ~q.master_select;
    assign match = addr & ((q.rx_sr[7:1] == q.sa) | (q.rx_sr == 8'h00));
    assign bit_idx = 4'h7 - q.bit_cnt;

    always_comb
    begin
        d = q;
        d.irq = 1'b0;
        // two-stage synchronisers, edge detection reads only later stages
        d.sy.scl_m = clock_line_pin_i;
        d.sy.scl_s = q.sy.scl_m;
        d.sy.scl_p = q.sy.scl_s;
        d.sy.sda_m = data_line_pin_i;
        d.sy.sda_s = q.sy.sda_m;
        d.sy.sda_p = q.sy.sda_s;

        // read data captured in the setup cycle so prdata is a flop
        if (psel & ~penable)
        begin
            d.slverr = 1'b0;
            case (paddr)
                `IBC_OFF_CR1: d.rdata = {24'h0, q.bc, q.ack_en, 4'h0};
                `IBC_OFF_CR2: d.rdata = {24'h0, q.master_select, q.transmit_select, q.bb, q.pin, 4'h0};
                `IBC_OFF_SR: d.rdata = {24'h0, q.master_select, q.transmit_select, q.bb, q.pin,
                    q.al, q.address_match_flag, q.general_call_flag, q.last_bit_monitor};
                `IBC_OFF_AR: d.rdata = {24'h0, q.sa, q.free_format_select};
                `IBC_OFF_DBR: d.rdata = {24'h0, q.rx_buf};
                default:
                begin
                    d.rdata = 32'h0;
                    d.slverr = 1'b1;
                end
            endcase
        end

        // software writes
        if (wr & (paddr == `IBC_OFF_CR1))
        begin
            d.bc = pwdata[`IBC_BC_MSB:`IBC_BC_LSB];
            d.ack_en = pwdata[`IBC_ACK_BIT];
        end
        if (wr & (paddr == `IBC_OFF_AR))
        begin
            d.sa = pwdata[7:1];
            d.free_format_select = pwdata[`IBC_ALS_BIT];
        end
        if (wr & (paddr == `IBC_OFF_DBR))
        begin
            d.tx_buf = pwdata[7:0];
            // a transmitter stalled at word end shows its msb at once
            if (q.active & q.transmit_select)
                d.sda_lo = ~pwdata[7];
        end
        // clears come first so any hardware set below wins
        if (dbr_acc)
        begin
            d.al = 1'b0;
            d.address_match_flag = 1'b0;
        end
        if (cr2_wr)
        begin
            d.al = 1'b0;
            d.master_select = pwdata[`IBC_MST_BIT];
            d.transmit_select = pwdata[`IBC_TRX_BIT];
        end
        if (start_req)
        begin
            if (q.bb)
            begin
                d.al = 1'b1;
                d.master_select = 1'b0;
                d.transmit_select = 1'b0;
            end
            else if (q.ph == ibc_pkg::ST_IDLE)
            begin
                d.ph = ibc_pkg::ST_START;
                d.sda_lo = 1'b1;
                d.tmr = HIGH_T;
            end
        end
        if (stop_req)
        begin
            d.ph = ibc_pkg::ST_STOP_A;
            d.sda_lo = 1'b1;
            d.tmr = LOW_T;
        end

        // start and stop seen on the bus
        if (start_det)
        begin
            d.bb = 1'b1;
            d.bc = 3'h0;
            d.general_call_flag = 1'b0;
            d.bit_cnt = 4'h0;
            d.first = 1'b1;
            d.active = 1'b1;
        end
        if (stop_det)
        begin
            d.bb = 1'b0;
            d.master_select = 1'b0;
            d.transmit_select = 1'b0;
            d.general_call_flag = 1'b0;
            d.active = 1'b0;
            d.first = 1'b0;
            d.slv_hold = 1'b0;
        end

        // clock rise: sample, monitor, arbitrate
        if (scl_rise & q.active)
        begin
            d.last_bit_monitor = q.sy.sda_s;
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt < wbits)
            begin
                d.rx_sr = {q.rx_sr[6:0], q.sy.sda_s};
                // released line read back low means another master won
                if (q.master_select & q.transmit_select & ~q.sda_lo & ~q.sy.sda_s)
                begin
                    d.al = 1'b1;
                    d.master_select = 1'b0;
                    d.transmit_select = 1'b0;
                    d.sda_lo = 1'b0;
                end
            end
        end

        // clock fall: present next bit, ack slot, or end the word
        if (scl_fall & q.active)
        begin
            if (data_done)
            begin
                d.rx_buf = q.rx_sr;
                if (match)
                begin
                    d.address_match_flag = 1'b1;
                    d.transmit_select = q.rx_sr[0];
                    if (q.rx_sr == 8'h00)
                        d.general_call_flag = 1'b1;
                end
                if (q.first & q.free_format_select & ~q.master_select)
                    d.address_match_flag = 1'b1;
                if (addr & ~match)
                    d.active = 1'b0;
                // receiver acks, transmitter lets go of the line
                d.sda_lo = q.ack_en & ~q.transmit_select & (~addr | match);
            end
            else
                d.sda_lo = q.transmit_select & ~q.tx_buf[bit_idx[2:0]];
            if (q.bit_cnt == wlen)
            begin
                d.sda_lo = 1'b0;
                d.bit_cnt = 4'h0;
                d.first = 1'b0;
                // direction follows only an acked address, never free data
                if (q.first & ~q.free_format_select & q.master_select & q.ack_en & ~q.last_bit_monitor)
                    d.transmit_select = ~q.tx_buf[0];
                if (q.master_select | d.address_match_flag | q.al)
                begin
                    d.irq = 1'b1;
                    if (~(q.al & ~d.address_match_flag))
                    begin
                        d.pin = 1'b0;
                        d.slv_hold = ~q.master_select;
                    end
                end
            end
        end

        // clock generation and stretching
        unique case (q.ph)
            ibc_pkg::ST_IDLE:
            begin
                // an addressed slave holds the clock until serviced
                if (q.slv_hold)
                begin
                    if (~q.pin)
                        d.tmr = LOW_T;
                    else if (q.tmr != 8'h0)
                        d.tmr = q.tmr - 8'h1;
                    else
                        d.slv_hold = 1'b0;
                end
            end
            ibc_pkg::ST_START:
            begin
                if (q.tmr != 8'h0)
                    d.tmr = q.tmr - 8'h1;
                else
                begin
                    d.scl_lo = 1'b1;
                    d.tmr = LOW_T;
                    d.ph = ibc_pkg::ST_XFER;
                end
            end
            ibc_pkg::ST_XFER:
            begin
                if (~d.master_select)
                begin
                    d.scl_lo = 1'b0;
                    d.ph = ibc_pkg::ST_IDLE;
                end
                else if (q.scl_lo)
                begin
                    if (~q.pin)
                        d.tmr = LOW_T;
                    else if (q.tmr != 8'h0)
                        d.tmr = q.tmr - 8'h1;
                    else
                    begin
                        d.scl_lo = 1'b0;
                        d.tmr = HIGH_T;
                    end
                end
                // high period counts only once the wired line is high
                else if (~q.sy.scl_s)
                    d.tmr = HIGH_T;
                else if (q.tmr != 8'h0)
                    d.tmr = q.tmr - 8'h1;
                else
                begin
                    d.scl_lo = 1'b1;
                    d.tmr = LOW_T;
                end
            end
            ibc_pkg::ST_STOP_A:
            begin
                if (q.tmr != 8'h0)
                    d.tmr = q.tmr - 8'h1;
                else
                begin
                    d.scl_lo = 1'b0;
                    d.tmr = HIGH_T;
                    d.ph = ibc_pkg::ST_STOP_B;
                end
            end
            ibc_pkg::ST_STOP_B:
            begin
                if (~q.sy.scl_s)
                    d.tmr = HIGH_T;
                else if (q.tmr != 8'h0)
                    d.tmr = q.tmr - 8'h1;
                else
                begin
                    d.sda_lo = 1'b0;
                    d.ph = ibc_pkg::ST_IDLE;
                end
            end
        endcase

        // software set of the service flag is last so it is never lost
        if (dbr_acc | (cr2_wr & pwdata[`IBC_PIN_BIT]))
            d.pin = 1'b1;
        d.scl_oe_n = ~(d.scl_lo | d.slv_hold);
        d.sda_oe_n = ~d.sda_lo;
    end

    // state register; idle bus levels preset so reset makes no false start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.pin <= `IBC_RST_PIN;
            q.sy <= '1;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end
        else
            q <= d;
    end

    // outputs
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = q.slverr;
    assign transfer_irq = q.irq;
    assign clock_line_pad = '{o: 1'b0, oe_n: q.scl_oe_n};
    assign data_line_pad = '{o: 1'b0, oe_n: q.sda_oe_n};

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_IRQ_PIN: assert property (q.irq && !(q.al && !q.address_match_flag) |-> !q.pin)
        else $error("interrupt did not clear service flag");
    AST_HOLD_SCL: assert property (q.slv_hold && !q.pin |=> !clock_line_pad.oe_n)
        else $error("clock line not held while service pending");
    AST_BB_SET: assert property (start_det |=> q.bb)
        else $error("busy flag not set after start");
    AST_BB_CLR: assert property (stop_det |=> !q.bb && !q.master_select && !q.transmit_select)
        else $error("stop did not clear busy, master or transmit");
    AST_BC_START: assert property (start_det |=> q.bc == 3'h0 && !q.general_call_flag)
        else $error("start did not reset bit count");
    AST_DBR_PIN: assert property (dbr_acc |=> q.pin)
        else $error("buffer access did not set service flag");
    AST_AL_ROLE: assert property ($rose(q.al) |-> !q.master_select && !q.transmit_select)
        else $error("lost arbitration kept master or transmit");
    AST_BUSY_START: assert property
        (start_req && q.bb |=> q.al && q.ph != ibc_pkg::ST_START)
        else $error("start while busy not refused");
    AST_LRB: assert property (scl_rise && q.active |=> q.last_bit_monitor == $past(q.sy.sda_s))
        else $error("last bit monitor wrong");
    AST_RELEASE: assert property (q.slv_hold && $rose(q.pin) |-> ##[1:300] !q.slv_hold)
        else $error("clock not released after service");
    // with ack clocks off the word must end on its last data bit
    AST_NO_ACK_CLK: assert property
        (scl_fall && q.active && !q.ack_en && data_done |=> q.bit_cnt == 4'h0)
        else $error("ack clock counted while ack mode off");

    COV_START: cover property (start_det ##[1:1000] q.irq);
    COV_AL: cover property ($rose(q.al));
    COV_GC: cover property ($rose(q.general_call_flag));
    COV_STOP: cover property (q.ph == ibc_pkg::ST_STOP_B ##[1:300] stop_det);
    COV_FREE: cover property ($rose(q.address_match_flag) && q.free_format_select);
endmodule : ibc_bus_ctrl

// File: verilog/ibc_cfg.svh
`ifndef IBC_CFG_SVH
`define IBC_CFG_SVH
// Operation
// - ack mode on: master adds an ack clock, slave counts it
// - transmitter releases the data line during the ack clock
// - receiver, or slave seeing general call, pulls data line low at ack clock
// - ack mode off: no ack clock generated or counted
// - bit count sets word length; start forces it to eight bits
// - own address matched in addressing format; free format takes first byte as data
// - master and transmit select are software bits; stop or lost arbitration clears them
// - free format never updates transmit select from a direction bit
// - acknowledged master address sets transmit select to inverted direction bit
// - addressed slave copies the received direction bit into transmit select
// - busy flag set on start, cleared on stop
// - start request while busy makes no start and flags lost arbitration
// - transfer interrupt clears service flag; clock line held low meanwhile
// - data buffer access or writing one sets service flag; release after delay
// - lost arbitration without address match: interrupt, service flag kept; with ack mode on, loss in an unmatched address byte gives no interrupt
// - master compares bus data with its own at clock rise; mismatch loses
// - lost arbitration clears master and transmit, stops clock output
// - lost flag cleared by data buffer access or second control write
// - address match flag set on match or free first word; buffer access clears
// - general call flag set on all-zero address, cleared on start or stop
// - last bit monitor holds data line sampled at clock rise
// - writing ones to master, transmit, busy and service starts a transfer
// - interrupt on falling edge of the last clock of each word; raised only as master or with lost or address match flag set

// register byte offsets
`define IBC_OFF_CR1 12'h000
`define IBC_OFF_CR2 12'h004
`define IBC_OFF_SR 12'h008
`define IBC_OFF_AR 12'h00c
`define IBC_OFF_DBR 12'h010
// field positions
`define IBC_BC_MSB 7
`define IBC_BC_LSB 5
`define IBC_ACK_BIT 4
`define IBC_MST_BIT 7
`define IBC_TRX_BIT 6
`define IBC_BB_BIT 5
`define IBC_PIN_BIT 4
`define IBC_ALS_BIT 0
// reset values
`define IBC_RST_PIN 1'b1
// timing
`define IBC_CLK_NS 50
`define IBC_T_LOW_NS 4700
`define IBC_T_HIGH_NS 4000
`define IBC_LOW_CYC ((`IBC_T_LOW_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_HIGH_CYC ((`IBC_T_HIGH_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`endif

// File: verilog/ibc_pkg.sv
package ibc_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_XFER, ST_STOP_A, ST_STOP_B} ibc_phase_t;

    // one open-drain pad: output level and active-low enable
    typedef struct packed {
        logic o;
        logic oe_n;
    } ibc_pad_t;

    // pin synchronisers, m is first stage, s stable, p previous
    typedef struct packed {
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
    } ibc_sync_t;

    typedef struct packed {
        ibc_phase_t ph;
        ibc_sync_t sy;
        logic [7:0] tmr;
        logic ack_en;
        logic [2:0] bc;
        logic [6:0] sa;
        logic free_format_select;
        logic master_select, transmit_select, bb, pin, al, address_match_flag, general_call_flag, last_bit_monitor;
        logic [7:0] tx_buf, rx_sr, rx_buf;
        logic [3:0] bit_cnt;
        logic first, active, scl_lo, sda_lo, slv_hold, irq, slverr;
        logic scl_oe_n, sda_oe_n;
        logic [31:0] rdata;
    } ibc_state_t;
endpackage : ibc_pkg

// File: bench/ibc_peer.sv
`timescale 1ns/10ps
// far side of the bus: a slave that acks its own address, and a scripted master
module ibc_peer #(
    parameter logic [6:0] PEER_ADDR = 7'h3a  // arbitrary slave address
) (
    input wire logic pclk,       // sampling clock
    input wire logic scl,        // resolved clock line
    input wire logic sda,        // resolved data line
    output logic scl_oe_n,       // low pulls clock line
    output logic sda_oe_n,       // low pulls data line
    output logic [7:0] got_byte  // first byte heard after a start
);
    logic scl_p = 1'b1;
    logic sda_p = 1'b1;
    logic ack_n = 1'b1;
    logic m_sda_n = 1'b1;
    logic [7:0] sh = 8'h00;
    logic [3:0] cnt = 4'ha;

    initial scl_oe_n = 1'b1;
    // both roles share one data pull; a released line floats to the pull-up
    assign sda_oe_n = ack_n & m_sda_n;

    // slave role: shift on clock rise, ack on the ninth clock when addressed
    always @(posedge pclk)
    begin
        scl_p <= scl;
        sda_p <= sda;
        if (scl && scl_p && sda_p && !sda)
            cnt <= 4'h0;
        else if (scl && !scl_p && cnt < 4'h8)
        begin
            sh <= {sh[6:0], sda};
            cnt <= cnt + 4'h1;
        end
        else if (!scl && scl_p && cnt == 4'h8)
        begin
            got_byte <= sh;
            ack_n <= (sh[7:1] != PEER_ADDR);
            cnt <= 4'h9;
        end
        else if (!scl && scl_p && cnt == 4'h9)
        begin
            ack_n <= 1'b1;
            cnt <= 4'ha;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // release the clock and wait out stretching, bounded so a hang cannot stall
    task automatic m_rise();
        int n;
        n = 0;
        scl_oe_n <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (scl !== 1'b1 && n < 600);
    endtask : m_rise

    // one bit: data moves a cycle after the clock falls, never with it
    task automatic m_bit(input logic b, output logic s);
        tick(1);
        m_sda_n <= b;
        tick(3);
        m_rise();
        tick(3);
        s = sda;
        scl_oe_n <= 1'b0;
    endtask : m_bit

    task automatic m_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            m_bit(d[i], s);
        m_bit(1'b1, ack);
    endtask : m_byte

    task automatic m_start();
        tick(1);
        m_sda_n <= 1'b0;
        tick(4);
        scl_oe_n <= 1'b0;
        tick(4);
    endtask : m_start

    task automatic m_stop();
        tick(1);
        m_sda_n <= 1'b0;
        tick(3);
        m_rise();
        tick(4);
        m_sda_n <= 1'b1;
        tick(4);
    endtask : m_stop
endmodule : ibc_peer

// File: bench/testbench.sv
`timescale 1ns/10ps
`include "ibc_cfg.svh"
module testbench;
    localparam int LOWC = 4;
    localparam logic [6:0] PEER = 7'h3a;  // arbitrary
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ibc_pkg::ibc_pad_t clock_line_pad;
    ibc_pkg::ibc_pad_t data_line_pad;
    logic transfer_irq;
    logic scl_w, sda_w, p_scl_oe_n, p_sda_oe_n, err_q, dir, ack;
    logic scl_d = 1'b1;
    logic [7:0] heard, fb;
    logic [6:0] sa, adr;
    logic [31:0] rd;
    int bad_count = 0;
    int total_checks = 0;
    int rises = 0;
    int n0;
    int cyc = 0;

    // open-drain lines with pull-ups
    assign scl_w = clock_line_pad.oe_n & p_scl_oe_n;
    assign sda_w = data_line_pad.oe_n & p_sda_oe_n;

    ibc_bus_ctrl #(.LOW_CYC(LOWC), .HIGH_CYC(4)) ibc_bus_ctrl_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_line_pin_i(scl_w), .data_line_pin_i(sda_w),
        .clock_line_pad(clock_line_pad), .data_line_pad(data_line_pad),
        .transfer_irq(transfer_irq));
    ibc_peer #(.PEER_ADDR(PEER)) ibc_peer_i (.pclk(pclk), .scl(scl_w), .sda(sda_w),
        .scl_oe_n(p_scl_oe_n), .sda_oe_n(p_sda_oe_n), .got_byte(heard));

    initial
    begin
        forever #25 pclk = ~pclk;
    end

    // clock rises on the bus, and a ceiling against hangs
    always @(posedge pclk)
    begin
        scl_d <= scl_w;
        if (scl_w && !scl_d)
            rises++;
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] sr_exp(input logic m, t, b, p, a, s, g, l);
        return {24'h0, m, t, b, p, a, s, g, l};
    endfunction : sr_exp

    // apb transfer: hold the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; it has no bound of its own, so the bench ceiling catches a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sr_is(input logic [31:0] exp);
        apb(1'b0, `IBC_OFF_SR, 32'h0);
        chk(rd, exp, "status");
    endtask : sr_is

    task automatic wait_irq();
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (transfer_irq !== 1'b1 && n < 3000);
        chk({31'h0, transfer_irq}, 32'h1, "word interrupt");
    endtask : wait_irq

    initial
    begin
        void'($urandom(32'hc37b8150));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err_q}, 32'h1, "unmapped");
        // slave side: own address with random direction, then general call
        sa = 7'h40 | 7'($urandom() & 32'h1f);
        apb(1'b1, `IBC_OFF_AR, {24'h0, sa, 1'b0});
        apb(1'b1, `IBC_OFF_CR1, 32'h10);
        for (int i = 0; i < 2; i++)
        begin
            dir = 1'($urandom());
            ibc_peer_i.m_start();
            sr_is(sr_exp(0, 0, 1, 1, 0, 0, 0, 0));
            ibc_peer_i.m_byte((i == 0) ? {sa, dir} : 8'h00, ack);
            chk({31'h0, ack}, 32'h0, "slave ack");
            repeat (3 * LOWC) @(posedge pclk);
            chk({31'h0, clock_line_pad.oe_n}, 32'h0, "stretch");
            sr_is(sr_exp(0, (i == 0) & dir, 1, 0, 0, 1, i == 1, 0));
            apb(1'b1, `IBC_OFF_DBR, 32'hff);
            sr_is(sr_exp(0, (i == 0) & dir, 1, 1, 0, 0, i == 1, 0));
            ibc_peer_i.m_stop();
            sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
        end
        // master side: acked address, one nobody answers, one with ack clocks off
        for (int i = 0; i < 3; i++)
        begin
            dir = 1'($urandom());
            adr = (i == 0) ? PEER : 7'h11;
            sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
            // last pass programs a short word that the start must undo
            apb(1'b1, `IBC_OFF_CR1, (i == 2) ? 32'ha0 : 32'h10);
            apb(1'b1, `IBC_OFF_DBR, {24'h0, adr, dir});
            n0 = rises;
            apb(1'b1, `IBC_OFF_CR2, 32'hf0);
            wait_irq();
            chk(32'(rises - n0), (i == 2) ? 32'd8 : 32'd9, "clocks per word");
            apb(1'b0, `IBC_OFF_CR1, 32'h0);
            chk(rd, (i == 2) ? 32'h0 : 32'h10, "control one");
            chk({24'h0, heard}, {24'h0, adr, dir}, "address byte");
            sr_is(sr_exp(1, (i == 0) ? !dir : 1'b1, 1, 0, 0, 0, 0,
                (i == 1) | ((i == 2) & dir)));
            repeat (3 * LOWC) @(posedge pclk);
            chk({31'h0, clock_line_pad.oe_n}, 32'h0, "clock hold");
            apb(1'b1, `IBC_OFF_CR2, 32'hd0);
            repeat (60) @(posedge pclk);
            sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
        end
        // start asked while another master holds the bus
        ibc_peer_i.m_start();
        apb(1'b1, `IBC_OFF_CR2, 32'hf0);
        repeat (20) @(posedge pclk);
        sr_is(sr_exp(0, 0, 1, 1, 1, 0, 0, 0));
        apb(1'b1, `IBC_OFF_CR2, 32'h10);
        sr_is(sr_exp(0, 0, 1, 1, 0, 0, 0, 0));
        ibc_peer_i.m_stop();
        sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
        // free format: first byte is plain data and leaves transmit select alone
        fb = 8'($urandom());
        apb(1'b1, `IBC_OFF_CR1, 32'h10);
        apb(1'b1, `IBC_OFF_AR, {24'h0, sa, 1'b1});
        ibc_peer_i.m_start();
        ibc_peer_i.m_byte(fb, ack);
        chk({31'h0, ack}, 32'h0, "free ack");
        repeat (3 * LOWC) @(posedge pclk);
        sr_is(sr_exp(0, 0, 1, 0, 0, 1, 0, 0));
        apb(1'b0, `IBC_OFF_DBR, 32'h0);
        chk(rd, {24'h0, fb}, "free byte");
        sr_is(sr_exp(0, 0, 1, 1, 0, 0, 0, 0));
        ibc_peer_i.m_stop();
        sr_is(sr_exp(0, 0, 0, 1, 0, 0, 0, 0));
        test_done();
    end
endmodule : testbench
